/* hw/line_if_params.svh */
// register map, field positions, reset values and timing of the line interface register bank
// assumes a 100 MHz mclk and a host driving the serial port synchronously to it
// Function
// - any reset-register write restores all defaults
// - reset register is write-only, stores nothing
// - global config bit 2 selects E1 or T1/J1
// - config bits 1-0 choose interrupt pin style
// - read-only revision byte at address zero
// - software reset completes within one microsecond
// - reading interrupt status releases interrupt pin
// - serial word: command byte then data byte
`ifndef LINE_IF_PARAMS_SVH
`define LINE_IF_PARAMS_SVH

`define ADDR_REVISION       5'h00
`define ADDR_SOFT_RESET     5'h01
`define ADDR_GLOBAL_CONFIG  5'h02
`define ADDR_LINE_IMPEDANCE 5'h03
`define ADDR_JITTER_CFG     5'h04
`define ADDR_TX_CONFIG_0    5'h05
`define ADDR_TX_CONFIG_1    5'h06
`define ADDR_TX_CONFIG_2    5'h07
`define ADDR_TX_CONFIG_3    5'h08
`define ADDR_TX_CONFIG_4    5'h09
`define ADDR_RX_CONFIG_0    5'h0A
`define ADDR_RX_CONFIG_1    5'h0B
`define ADDR_RX_CONFIG_2    5'h0C
`define ADDR_DIAG_PATTERN   5'h0D
`define ADDR_LOOPBACK       5'h0E
`define ADDR_INBAND_LENGTH  5'h0F
`define ADDR_TX_INBAND_CODE 5'h10
`define ADDR_RX_ACT_CODE    5'h11
`define ADDR_RX_DEACT_CODE  5'h12
`define ADDR_ERR_INSERT     5'h13
`define ADDR_IRQ_MASK_0     5'h14
`define ADDR_IRQ_MASK_1     5'h15
`define ADDR_IRQ_EDGE_SEL   5'h16
`define ADDR_RW_LAST        5'h16
`define ADDR_LINE_STATUS_0  5'h17
`define ADDR_LINE_STATUS_1  5'h18
`define ADDR_IRQ_STATUS_0   5'h19
`define ADDR_IRQ_STATUS_1   5'h1A
`define ADDR_ERR_COUNT_LOW  5'h1B
`define ADDR_ERR_COUNT_HIGH 5'h1C

`define RW_REG_COUNT        21
`define IDX_JITTER_CFG      2
`define IDX_TX_CONFIG_1     4

`define GCF_STANDARD_BIT    2
`define GCF_PIN_PUSHPULL    0
`define GCF_PIN_ACTIVE_HIGH 1

`define RESET_GENERIC       8'h00
`define RESET_JITTER_CFG    8'h20
`define RESET_TX_CONFIG_1   8'h10
`define RESET_GLOBAL_CONFIG 8'h00

`define SERIAL_CMD_LAST     5'h07
`define SERIAL_WORD_LAST    5'h0F
`define SERIAL_WORD_BITS    5'h10

`define CLOCK_PERIOD_NS     10
`define SOFT_RESET_MAX_NS   1000
`define SOFT_RESET_MAX_CYC  (`SOFT_RESET_MAX_NS / `CLOCK_PERIOD_NS)

`endif

/* hw/line_if_pkg.sv */
// types of the line interface register bank
// assumes line_if_params.svh is included by the user of the widths
package line_if_pkg;

	typedef struct packed {
		logic            sclkPrev;
		logic [4:0]      bitCnt;
		logic [15:0]     shiftIn;
		logic [7:0]      shiftOut;
		logic            readCmd;
		logic [4:0]      addr;
		logic [20:0][7:0] rwRegs;
		logic [7:0]      irqStatus0;
		logic [7:0]      irqStatus1;
		logic [7:0]      statusPrev;
		logic [7:0]      countHighLatch;
		logic            irqOut;
		logic            irqOutEn;
		logic            serialOut;
		logic            serialOutEn;
	} bank_state_t;

endpackage : line_if_pkg

/* hw/line_interface_register_bank.sv */
// serial-port register bank: control registers, status capture, interrupt pin and counter view
// assumes every input is synchronous to mclk; sclk is sampled, not used as a clock
`timescale 1ns/100ps
`include "line_if_params.svh"

module line_interface_register_bank
	import line_if_pkg::*;
#(
	// arbitrary neutral value
	parameter logic [7:0] REVISION_CODE = 8'h5A
) (
	input  wire logic         mclk,
	input  wire logic         rstn,
	input  wire logic         chipSelectN,
	input  wire logic         sclk,
	input  wire logic         serialIn,
	input  wire logic [7:0]   lineStatus0,
	input  wire logic [7:0]   lineStatus1,
	input  wire logic [7:0]   irqEvent1,
	input  wire logic [15:0]  errorCount,
	output logic              serialOut,
	output logic              serialOutEn,
	output logic              irqOut,
	output logic              irqOutEn,
	output logic              lineStandardSelect,
	output logic [167:0]      ctrlRegs
);

	bank_state_t state;
	bank_state_t next_state;
	bank_state_t resetState;

	always_comb begin
		resetState = '0;
		for (int i = 0; i < `RW_REG_COUNT; i++) begin
			resetState.rwRegs[i] = `RESET_GENERIC;
		end
		resetState.rwRegs[0] = `RESET_GLOBAL_CONFIG;
		resetState.rwRegs[`IDX_JITTER_CFG] = `RESET_JITTER_CFG;
		resetState.rwRegs[`IDX_TX_CONFIG_1] = `RESET_TX_CONFIG_1;
	end

	function automatic logic [7:0] read_reg(input bank_state_t s, input logic [4:0] a,
			input logic [7:0] st0, input logic [7:0] st1, input logic [15:0] cnt);
		logic [7:0] d;
		d = 8'h00;
		case (a)
			`ADDR_REVISION: begin
				d = REVISION_CODE;
			end
			`ADDR_GLOBAL_CONFIG: begin
				d = s.rwRegs[`ADDR_GLOBAL_CONFIG - `ADDR_GLOBAL_CONFIG];
			end
			`ADDR_LINE_IMPEDANCE: begin
				d = s.rwRegs[`ADDR_LINE_IMPEDANCE - `ADDR_GLOBAL_CONFIG];
			end
			`ADDR_JITTER_CFG: begin
				d = s.rwRegs[`ADDR_JITTER_CFG - `ADDR_GLOBAL_CONFIG];
			end
			`ADDR_TX_CONFIG_0: begin
				d = s.rwRegs[`ADDR_TX_CONFIG_0 - `ADDR_GLOBAL_CONFIG];
			end
			`ADDR_TX_CONFIG_1: begin
				d = s.rwRegs[`ADDR_TX_CONFIG_1 - `ADDR_GLOBAL_CONFIG];
			end
			`ADDR_TX_CONFIG_2: begin
				d = s.rwRegs[`ADDR_TX_CONFIG_2 - `ADDR_GLOBAL_CONFIG];
			end
			`ADDR_TX_CONFIG_3: begin
				d = s.rwRegs[`ADDR_TX_CONFIG_3 - `ADDR_GLOBAL_CONFIG];
			end
			`ADDR_TX_CONFIG_4: begin
				d = s.rwRegs[`ADDR_TX_CONFIG_4 - `ADDR_GLOBAL_CONFIG];
			end
			`ADDR_RX_CONFIG_0: begin
				d = s.rwRegs[`ADDR_RX_CONFIG_0 - `ADDR_GLOBAL_CONFIG];
			end
			`ADDR_RX_CONFIG_1: begin
				d = s.rwRegs[`ADDR_RX_CONFIG_1 - `ADDR_GLOBAL_CONFIG];
			end
			`ADDR_RX_CONFIG_2: begin
				d = s.rwRegs[`ADDR_RX_CONFIG_2 - `ADDR_GLOBAL_CONFIG];
			end
			`ADDR_DIAG_PATTERN: begin
				d = s.rwRegs[`ADDR_DIAG_PATTERN - `ADDR_GLOBAL_CONFIG];
			end
			`ADDR_LOOPBACK: begin
				d = s.rwRegs[`ADDR_LOOPBACK - `ADDR_GLOBAL_CONFIG];
			end
			`ADDR_INBAND_LENGTH: begin
				d = s.rwRegs[`ADDR_INBAND_LENGTH - `ADDR_GLOBAL_CONFIG];
			end
			`ADDR_TX_INBAND_CODE: begin
				d = s.rwRegs[`ADDR_TX_INBAND_CODE - `ADDR_GLOBAL_CONFIG];
			end
			`ADDR_RX_ACT_CODE: begin
				d = s.rwRegs[`ADDR_RX_ACT_CODE - `ADDR_GLOBAL_CONFIG];
			end
			`ADDR_RX_DEACT_CODE: begin
				d = s.rwRegs[`ADDR_RX_DEACT_CODE - `ADDR_GLOBAL_CONFIG];
			end
			`ADDR_ERR_INSERT: begin
				d = s.rwRegs[`ADDR_ERR_INSERT - `ADDR_GLOBAL_CONFIG];
			end
			`ADDR_IRQ_MASK_0: begin
				d = s.rwRegs[`ADDR_IRQ_MASK_0 - `ADDR_GLOBAL_CONFIG];
			end
			`ADDR_IRQ_MASK_1: begin
				d = s.rwRegs[`ADDR_IRQ_MASK_1 - `ADDR_GLOBAL_CONFIG];
			end
			`ADDR_IRQ_EDGE_SEL: begin
				d = s.rwRegs[`ADDR_IRQ_EDGE_SEL - `ADDR_GLOBAL_CONFIG];
			end
			`ADDR_LINE_STATUS_0: begin
				d = st0;
			end
			`ADDR_LINE_STATUS_1: begin
				d = st1;
			end
			`ADDR_IRQ_STATUS_0: begin
				d = s.irqStatus0;
			end
			`ADDR_IRQ_STATUS_1: begin
				d = s.irqStatus1;
			end
			`ADDR_ERR_COUNT_LOW: begin
				d = cnt[7:0];
			end
			`ADDR_ERR_COUNT_HIGH: begin
				d = s.countHighLatch;
			end
			// reset register and unmapped addresses read zero
			default: begin
				d = 8'h00;
			end
		endcase
		return d;
	endfunction : read_reg

	always_comb begin
		logic       rise;
		logic       fall;
		logic [7:0] cmd;
		logic [7:0] wdata;
		logic [7:0] edges;
		logic [7:0] clr0;
		logic [7:0] clr1;
		logic       softReset;
		logic       irqActive;
		logic [1:0] pinMode;
		rise = 1'b0;
		fall = 1'b0;
		cmd = 8'h00;
		wdata = 8'h00;
		edges = 8'h00;
		clr0 = 8'h00;
		clr1 = 8'h00;
		softReset = 1'b0;
		irqActive = 1'b0;
		pinMode = 2'b00;
		next_state = state;
		next_state.sclkPrev = sclk;
		rise = sclk & ~state.sclkPrev;
		fall = ~sclk & state.sclkPrev;

		if (chipSelectN) begin
			next_state.bitCnt = 5'h00;
			next_state.serialOutEn = 1'b0;
			next_state.readCmd = 1'b0;
		end else if (rise && state.bitCnt < `SERIAL_WORD_BITS) begin
			next_state.shiftIn = {serialIn, state.shiftIn[15:1]};
			next_state.bitCnt = state.bitCnt + 5'h01;
			if (state.bitCnt == `SERIAL_CMD_LAST) begin
				cmd = {serialIn, state.shiftIn[15:9]};
				next_state.readCmd = cmd[0];
				next_state.addr = cmd[5:1];
				if (cmd[0]) begin
					next_state.shiftOut = read_reg(state, cmd[5:1], lineStatus0,
						lineStatus1, errorCount);
					next_state.serialOut = next_state.shiftOut[0];
					next_state.serialOutEn = 1'b1;
					if (cmd[5:1] == `ADDR_IRQ_STATUS_0) begin
						clr0 = 8'hFF;
					end
					if (cmd[5:1] == `ADDR_IRQ_STATUS_1) begin
						clr1 = 8'hFF;
					end
					if (cmd[5:1] == `ADDR_ERR_COUNT_LOW) begin
						next_state.countHighLatch = errorCount[15:8];
					end
				end
			end
			if (state.bitCnt == `SERIAL_WORD_LAST && !state.readCmd) begin
				wdata = {serialIn, state.shiftIn[15:9]};
				case (state.addr)
					`ADDR_SOFT_RESET: begin
						softReset = 1'b1;
					end
					`ADDR_GLOBAL_CONFIG,
					`ADDR_LINE_IMPEDANCE,
					`ADDR_JITTER_CFG,
					`ADDR_TX_CONFIG_0,
					`ADDR_TX_CONFIG_1,
					`ADDR_TX_CONFIG_2,
					`ADDR_TX_CONFIG_3,
					`ADDR_TX_CONFIG_4,
					`ADDR_RX_CONFIG_0,
					`ADDR_RX_CONFIG_1,
					`ADDR_RX_CONFIG_2,
					`ADDR_DIAG_PATTERN,
					`ADDR_LOOPBACK,
					`ADDR_INBAND_LENGTH,
					`ADDR_TX_INBAND_CODE,
					`ADDR_RX_ACT_CODE,
					`ADDR_RX_DEACT_CODE,
					`ADDR_ERR_INSERT,
					`ADDR_IRQ_MASK_0,
					`ADDR_IRQ_MASK_1,
					`ADDR_IRQ_EDGE_SEL: begin
						next_state.rwRegs[state.addr - `ADDR_GLOBAL_CONFIG] = wdata;
					end
					// read-only and unmapped addresses ignore writes
					default: begin
					end
				endcase
			end
		end else if (fall && state.readCmd && state.bitCnt > 5'h08
				&& state.bitCnt < `SERIAL_WORD_BITS) begin
			next_state.shiftOut = {1'b0, state.shiftOut[7:1]};
			next_state.serialOut = state.shiftOut[1];
		end

		// status edges; edge-select one also catches falling
		next_state.statusPrev = lineStatus0;
		for (int i = 0; i < 8; i++) begin
			edges[i] = (lineStatus0[i] & ~state.statusPrev[i])
				| (state.rwRegs[`ADDR_RW_LAST - `ADDR_GLOBAL_CONFIG][i]
				& ~lineStatus0[i] & state.statusPrev[i]);
		end
		// set wins over read clear
		next_state.irqStatus0 = (state.irqStatus0 & ~clr0) | edges;
		next_state.irqStatus1 = (state.irqStatus1 & ~clr1) | irqEvent1;

		irqActive = |(next_state.irqStatus0 & next_state.rwRegs[18])
			| |(next_state.irqStatus1 & next_state.rwRegs[19]);
		if (clr0 != 8'h00 || clr1 != 8'h00) begin
			irqActive = 1'b0;
		end

		if (softReset) begin
			next_state.rwRegs = resetState.rwRegs;
			next_state.irqStatus0 = resetState.irqStatus0;
			next_state.irqStatus1 = resetState.irqStatus1;
			next_state.countHighLatch = resetState.countHighLatch;
			irqActive = 1'b0;
		end

		pinMode = next_state.rwRegs[0][1:0];
		case (pinMode)
			// open drain: only the enable moves
			2'b00, 2'b10: begin
				next_state.irqOut = 1'b0;
				next_state.irqOutEn = irqActive;
			end
			2'b11: begin
				next_state.irqOut = irqActive;
				next_state.irqOutEn = 1'b1;
			end
			2'b01: begin
				next_state.irqOut = ~irqActive;
				next_state.irqOutEn = 1'b1;
			end
			default: begin
				next_state.irqOut = 1'b0;
				next_state.irqOutEn = 1'b0;
			end
		endcase
	end

	always_ff @(posedge mclk) begin
		if (!rstn) begin
			state <= resetState;
		end else begin
			state <= next_state;
		end
	end

	assign serialOut = state.serialOut;
	assign serialOutEn = state.serialOutEn;
	assign irqOut = state.irqOut;
	assign irqOutEn = state.irqOutEn;
	assign lineStandardSelect = state.rwRegs[0][`GCF_STANDARD_BIT];
	assign ctrlRegs = state.rwRegs;

endmodule : line_interface_register_bank

/* test/line_bank_chk.sv */
// port assertions for the register bank
// assumes one mclk domain, bound to the bank top
`timescale 1ns/100ps
module line_bank_chk (
	input wire logic         mclk,
	input wire logic         rstn,
	input wire logic         chipSelectN,
	input wire logic         sclk,
	input wire logic         serialOut,
	input wire logic         serialOutEn,
	input wire logic         irqOut,
	input wire logic         irqOutEn,
	input wire logic         lineStandardSelect,
	input wire logic [167:0] ctrlRegs
);
	default clocking @(posedge mclk); endclocking
	default disable iff (!rstn);
	sequence sFrameEnd;
		chipSelectN;
	endsequence
	a_reset_defaults: assert property ($rose(rstn) |-> ctrlRegs[23:16] == 8'h20
		&& ctrlRegs[39:32] == 8'h10 && !lineStandardSelect) else $error("bad defaults");
	a_standard_bit: assert property (lineStandardSelect == ctrlRegs[2])
		else $error("standard bit");
	a_pushpull_en: assert property (ctrlRegs[0] && $past(ctrlRegs[0]) |-> irqOutEn)
		else $error("push-pull not driven");
	a_opendrain_low: assert property (!ctrlRegs[0] && !$past(ctrlRegs[0]) |-> !irqOut)
		else $error("open drain high");
	a_out_release: assert property (sFrameEnd |=> !serialOutEn)
		else $error("serial out held");
	a_out_idle: assert property ($fell(chipSelectN) |-> !serialOutEn)
		else $error("serial out early");
	a_write_framed: assert property ($changed(ctrlRegs) |-> !$past(chipSelectN))
		else $error("register change outside frame");
	a_dout_stable: assert property (serialOutEn && $past(serialOutEn) && sclk
		&& $past(sclk) |-> $stable(serialOut)) else $error("data moved while sclk high");
endmodule : line_bank_chk
bind line_interface_register_bank line_bank_chk chk_i (.mclk, .rstn, .chipSelectN, .sclk,
	.serialOut, .serialOutEn, .irqOut, .irqOutEn, .lineStandardSelect, .ctrlRegs);

/* test/serial_host.sv */
// host model of the serial register port
// assumes the bank samples sclk with this mclk
`timescale 1ns/100ps
module serial_host (
	input  wire logic mclk,
	input  wire logic serialOut,
	output logic      chipSelectN,
	output logic      sclk,
	output logic      serialIn
);
	initial begin
		chipSelectN = 1'b1;
		sclk = 1'b0;
		serialIn = 1'b0;
	end
	task automatic xfer(input logic [15:0] w, output logic [7:0] q);
		q = 8'h00;
		@(posedge mclk) chipSelectN <= 1'b0;
		for (int i = 0; i < 16; i++) begin
			@(posedge mclk) serialIn <= w[i];
			@(posedge mclk) sclk <= 1'b1;
			if (i > 7) q[i-8] = serialOut;
			@(posedge mclk);
			@(posedge mclk) sclk <= 1'b0;
		end
		@(posedge mclk) chipSelectN <= 1'b1;
		serialIn <= ~serialIn;
	endtask : xfer
endmodule : serial_host

/* test/tb_top.sv */
// register bank bench driven through the serial host model
// assumes the host model and checker compiled first
`timescale 1ns/100ps
module tb_top;
	localparam logic [7:0] REV = 8'hA5; // arbitrary
	logic         mclk, rstn, chipSelectN, sclk, serialIn, serialOut, serialOutEn;
	logic         irqOut, irqOutEn, lineStandardSelect;
	logic [7:0]   lineStatus0, lineStatus1, irqEvent1, q;
	logic [15:0]  errorCount;
	logic [167:0] ctrlRegs;
	int           nErrors, numChecks;
	line_interface_register_bank #(.REVISION_CODE(REV)) line_interface_register_bank_i (
		.mclk, .rstn, .chipSelectN, .sclk, .serialIn, .lineStatus0, .lineStatus1, .irqEvent1,
		.errorCount, .serialOut, .serialOutEn, .irqOut, .irqOutEn, .lineStandardSelect, .ctrlRegs);
	serial_host serial_host_i (.mclk, .serialOut, .chipSelectN, .sclk, .serialIn);
	initial begin
		mclk = 1'b0;
		forever #5 mclk = ~mclk;
	end
	task chk(input logic [7:0] got, input logic [7:0] exp);
		numChecks++;
		if (got !== exp) begin
			nErrors++;
			$display("mismatch at %0t: got %h want %h", $time, got, exp);
		end
	endtask : chk
	task wr(input logic [4:0] a, input logic [7:0] d);
		serial_host_i.xfer({d, 2'b00, a, 1'b0}, q);
	endtask : wr
	task rd(input logic [4:0] a, input logic [7:0] e);
		serial_host_i.xfer({10'h000, a, 1'b1}, q);
		chk(q, e);
	endtask : rd
	task endSim;
		if (nErrors == 0 && numChecks > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : endSim
	initial begin
		repeat (20000) @(posedge mclk);
		nErrors++;
		endSim;
	end
	initial begin
		rstn = 1'b0;
		lineStatus0 = 8'h00;
		lineStatus1 = 8'h3C;
		irqEvent1 = 8'h00;
		errorCount = 16'hBEEF;
		repeat (3) @(posedge mclk);
		rstn <= 1'b1;
		wr(5'h00, 8'hFF);
		rd(5'h00, REV);
		rd(5'h1D, 8'h00);
		rd(5'h18, 8'h3C);
		rd(5'h1B, 8'hEF);
		errorCount <= 16'h1234;
		rd(5'h1C, 8'hBE);
		wr(5'h15, 8'hFF);
		for (int m = 0; m < 4; m++) begin
			wr(5'h02, {6'h01, m[1:0]});
			@(posedge mclk) irqEvent1 <= 8'h01;
			@(posedge mclk) irqEvent1 <= 8'h00;
			repeat (2) @(posedge mclk);
			#1 chk({6'h00, irqOut, irqOutEn}, {6'h00, m == 3, 1'b1});
			rd(5'h1A, 8'h01);
			chk({6'h00, irqOut, irqOutEn}, {6'h00, m == 1, m[0]});
		end
		chk({7'h00, lineStandardSelect}, 8'h01);
		rd(5'h02, 8'h07);
		wr(5'h04, 8'h00);
		wr(5'h01, 8'h55);
		chk(ctrlRegs[23:16], 8'h20);
		rd(5'h02, 8'h00);
		rd(5'h06, 8'h10);
		rd(5'h01, 8'h00);
		chk({7'h00, lineStandardSelect}, 8'h00);
		lineStatus0 <= 8'h81;
		rd(5'h17, 8'h81);
		rd(5'h19, 8'h81);
		rd(5'h19, 8'h00);
		wr(5'h16, 8'h01);
		wr(5'h14, 8'h01);
		lineStatus0 <= 8'h80;
		repeat (2) @(posedge mclk);
		#1 chk({6'h00, irqOut, irqOutEn}, 8'h01);
		rd(5'h19, 8'h01);
		chk({6'h00, irqOut, irqOutEn}, 8'h00);
		endSim;
	end
endmodule : tb_top
